// *** rtl/pem_cfg.svh ***
// Constants of the performance event monitor: register numbers, fields, resets, vectors.
`ifndef PEM_CFG_SVH
`define PEM_CFG_SVH

// Special register numbers.
`define PEM_SPR_CTRL0 10'h3b8
`define PEM_SPR_CNT1 10'h3b9
`define PEM_SPR_CNT2 10'h3ba
`define PEM_SPR_SIA 10'h3bb
`define PEM_SPR_CTRL1 10'h3bc
`define PEM_SPR_CNT3 10'h3bd
`define PEM_SPR_CNT4 10'h3be
`define PEM_SPR_SDA 10'h3bf

// Control register 0 fields (bit 0 is the least significant bit).
`define PEM_C0_ARM 26
`define PEM_C0_FREEZE 25
`define PEM_C0_TB_SEL_HI 24
`define PEM_C0_TB_SEL_LO 23
`define PEM_C0_TB_IRQ_EN 22
`define PEM_C0_CTR_IRQ_EN 15
`define PEM_C0_SEL1_HI 12
`define PEM_C0_SEL1_LO 6
`define PEM_C0_SEL2_HI 5
`define PEM_C0_SEL2_LO 0

// Control register 1 fields.
`define PEM_C1_SEL3_HI 31
`define PEM_C1_SEL3_LO 27
`define PEM_C1_SEL4_HI 26
`define PEM_C1_SEL4_LO 22

// Time base lower word bits watched for a rising edge, per select value 0..3.
`define PEM_TB_BIT0 16
`define PEM_TB_BIT1 12
`define PEM_TB_BIT2 8
`define PEM_TB_BIT3 0

// Event select codes with fixed meaning.
`define PEM_EV_HOLD 7'h00
`define PEM_EV_CYCLE 7'h01
`define PEM_EV_TB 7'h03

// Reset values.
`define PEM_RST_WORD 32'h0000_0000

// Exception vector offset of the monitor interrupt.
`define PEM_VEC_MON 20'h00f00

`endif

// *** rtl/pem_counter.sv ***
// One event counter with software load and multi-event increment.
`default_nettype none
module pem_counter #(
  parameter int W = 32,
  parameter int IW = 3
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic cnt_en,
  input wire logic [IW-1:0] inc,
  output logic [W-1:0] value,
  output logic negative
);
  logic [W-1:0] value_q;

  // A load in the same cycle as an increment wins; the sum wraps naturally.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      value_q <= '0;
    end else if (load) begin
      value_q <= load_val;
    end else if (cnt_en) begin
      value_q <= value_q + W'(inc);
    end
  end

  assign value = value_q;
  assign negative = value_q[W-1];
endmodule
`default_nettype wire

// *** rtl/pem_monitor.sv ***
// Performance event monitor: counters, control, sampling and interrupt request.
`default_nettype none
`include "pem_cfg.svh"

// Functional notes
// - Four independent 32-bit counters each count occurrences of their selected event.
// - A counter is negative whenever its top bit is one.
// - Negative counter interrupts only with counter enable and arm bits both set.
// - Interrupt condition with external enable clear waits until that enable is set.
// - A rising edge of the selected time base bit can also interrupt.
// - Threshold event interrupt captures the exact responsible instruction and data address.
// - Other events capture last completed instruction address and current operand address.
// - Interrupt clears the arm bit and freezes samples until software rearms.
// - With freeze-on-interrupt set, counters stop when a counter interrupt occurs.
// - Counters are read and written at register numbers 953, 954, 957, 958.
// - The monitor interrupt vectors to offset 0x00F00.
// - Monitor interrupt ranks below external and above decrementer interrupts.
// - Events for counters one and two come from control register 0 bits 19-31.
// - Counting runs from reset; only a counter interrupt with freeze-on-interrupt set stops it, until a control 0 write.
// - All registers supervisor only: controls 952, 956, samples 955, 959.
// - Counter one code 0 holds the count, code 1 counts every cycle.
// - Counter two event comes from control register 0 bits 26-31.
module pem_monitor #(
  parameter int NUM_EVT = 32,
  parameter int EW = 3,
  parameter logic [31:0] THRESH_MASK = 32'h0180_0600,
  parameter logic [19:0] EXT_VEC = 20'h00000,
  parameter logic [19:0] DEC_VEC = 20'h00000
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [9:0] spr_num,
  input wire logic spr_wr,
  input wire logic spr_rd,
  input wire logic [31:0] spr_wdata,
  input wire logic spr_supervisor,
  output logic [31:0] spr_rdata,
  output logic spr_rvalid,
  output logic spr_fault,
  input wire logic [NUM_EVT*EW-1:0] evt_count,
  input wire logic [31:0] tb_lower,
  input wire logic [31:0] thr_iaddr,
  input wire logic [31:0] thr_daddr,
  input wire logic [31:0] cmpl_iaddr,
  input wire logic [31:0] opnd_daddr,
  input wire logic external_irq_enable_bit,
  input wire logic ext_irq_req,
  input wire logic dec_irq_req,
  input wire logic exc_ack,
  output logic exc_req,
  output pem_pkg::pem_src_e exc_src,
  output logic [19:0] exc_vector,
  output logic monitor_interrupt_pending
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************

  // Map a register number to a counter index; 3'd4 means not a counter.
  function automatic logic [2:0] cnt_index(input logic [9:0] num);
    case (num)
      `PEM_SPR_CNT1: cnt_index = 3'h0;
      `PEM_SPR_CNT2: cnt_index = 3'h1;
      `PEM_SPR_CNT3: cnt_index = 3'h2;
      `PEM_SPR_CNT4: cnt_index = 3'h3;
      default: cnt_index = 3'h4;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [9:0] num);
    is_mapped = (num >= `PEM_SPR_CTRL0) && (num <= `PEM_SPR_SDA);
  endfunction

  // Occurrences of the selected event in this cycle.
  function automatic logic [EW-1:0] pick_count(input logic [6:0] code,
                                                input logic [NUM_EVT*EW-1:0] ev,
                                                input logic tb_rise);
    logic [EW-1:0] res;
    res = '0;
    case (code)
      `PEM_EV_HOLD: res = '0;
      `PEM_EV_CYCLE: res = EW'(1);
      `PEM_EV_TB: res = EW'(tb_rise);
      default: begin
        if (int'(code) < NUM_EVT) begin
          res = ev[int'(code)*EW +: EW];
        end
      end
    endcase
    pick_count = res;
  endfunction

  function automatic logic is_thresh(input logic [6:0] code);
    is_thresh = (int'(code) < NUM_EVT) && (int'(code) < 32) && THRESH_MASK[code[4:0]];
  endfunction

  // ****************************************************************
  // Register access
  // ****************************************************************

  logic acc_ok;
  logic acc_any;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic [2:0] wr_idx;
  logic [31:0] ctrl0_q;
  logic [31:0] ctrl1_q;
  logic [31:0] sia_q;
  logic [31:0] sda_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic fault_q;

  assign acc_any = spr_wr | spr_rd;
  // Register moves from user state are refused and flagged.
  assign acc_ok = spr_supervisor & is_mapped(spr_num);
  assign wr_ctrl0 = spr_wr & acc_ok & (spr_num == `PEM_SPR_CTRL0);
  assign wr_ctrl1 = spr_wr & acc_ok & (spr_num == `PEM_SPR_CTRL1);
  assign wr_idx = (spr_wr & acc_ok) ? cnt_index(spr_num) : 3'h4;

  // ****************************************************************
  // Time base edge
  // ****************************************************************

  logic [1:0] tb_sel;
  logic tb_bit;
  logic tb_bit_q;
  logic tb_rise;

  assign tb_sel = ctrl0_q[`PEM_C0_TB_SEL_HI:`PEM_C0_TB_SEL_LO];

  always_comb begin
    case (tb_sel)
      2'h0: tb_bit = tb_lower[`PEM_TB_BIT0];
      2'h1: tb_bit = tb_lower[`PEM_TB_BIT1];
      2'h2: tb_bit = tb_lower[`PEM_TB_BIT2];
      default: tb_bit = tb_lower[`PEM_TB_BIT3];
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      tb_bit_q <= 1'b0;
    end else begin
      tb_bit_q <= tb_bit;
    end
  end

  assign tb_rise = tb_bit & ~tb_bit_q;

  // ****************************************************************
  // Counters
  // ****************************************************************

  logic [6:0] sel [4];
  logic [31:0] cnt_val [4];
  logic [3:0] cnt_neg;
  logic [3:0] cnt_neg_q;
  logic [3:0] thr_q;
  logic frozen_q;
  logic cnt_run;

  // Counter one takes seven select bits, counter two six.
  assign sel[0] = ctrl0_q[`PEM_C0_SEL1_HI:`PEM_C0_SEL1_LO];
  assign sel[1] = {1'b0, ctrl0_q[`PEM_C0_SEL2_HI:`PEM_C0_SEL2_LO]};
  assign sel[2] = {2'b00, ctrl1_q[`PEM_C1_SEL3_HI:`PEM_C1_SEL3_LO]};
  assign sel[3] = {2'b00, ctrl1_q[`PEM_C1_SEL4_HI:`PEM_C1_SEL4_LO]};

  assign cnt_run = ~frozen_q;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_cnt
      // Hold and every-cycle codes are decoded in pick_count.
      pem_counter #(
        .W(32),
        .IW(EW)
      ) u_cnt (
        .clk_sys(clk_sys),
        .srst(srst),
        .load(wr_idx == 3'(i)),
        .load_val(spr_wdata),
        .cnt_en(cnt_run),
        .inc(pick_count(sel[i], evt_count, tb_rise)),
        .value(cnt_val[i]),
        .negative(cnt_neg[i])
      );

      // Remember whether the last counted event was a threshold event.
      always_ff @(posedge clk_sys) begin
        if (srst) begin
          thr_q[i] <= 1'b0;
        end else if (cnt_run && (pick_count(sel[i], evt_count, tb_rise) != '0)) begin
          thr_q[i] <= is_thresh(sel[i]);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cnt_neg_q <= 4'h0;
    end else begin
      cnt_neg_q <= cnt_neg;
    end
  end

  // ****************************************************************
  // Interrupt condition
  // ****************************************************************

  logic arm;
  logic ctr_irq;
  logic tb_irq;
  logic mon_fire;
  logic thr_fire;

  assign arm = ctrl0_q[`PEM_C0_ARM];
  // Counter interrupt needs both enables; a negative load may fire at once.
  assign ctr_irq = (|cnt_neg) & ctrl0_q[`PEM_C0_CTR_IRQ_EN] & arm;
  assign tb_irq = tb_rise & ctrl0_q[`PEM_C0_TB_IRQ_EN] & arm;
  assign mon_fire = ctr_irq | tb_irq;
  assign thr_fire = ctr_irq & (|(cnt_neg & ~cnt_neg_q & thr_q));

  // Software owns control 0; hardware only drops the arm bit on firing.
  // A same-cycle write wins so that a rearm is never lost.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl0_q <= `PEM_RST_WORD;
    end else if (wr_ctrl0) begin
      ctrl0_q <= spr_wdata;
    end else if (mon_fire) begin
      ctrl0_q[`PEM_C0_ARM] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctrl1_q <= `PEM_RST_WORD;
    end else if (wr_ctrl1) begin
      ctrl1_q <= spr_wdata;
    end
  end

  // Freeze ends only with a new control 0 value.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      frozen_q <= 1'b0;
    end else if (ctr_irq && ctrl0_q[`PEM_C0_FREEZE]) begin
      frozen_q <= 1'b1;
    end else if (wr_ctrl0) begin
      frozen_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Address sampling
  // ****************************************************************

  logic [31:0] thr_iaddr_q;
  logic [31:0] thr_daddr_q;
  logic [31:0] cmpl_iaddr_q;
  logic [31:0] opnd_daddr_q;

  // The counter turns negative one cycle after its event, so the addresses of
  // that event are held one cycle to line up with the firing.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      thr_iaddr_q <= `PEM_RST_WORD;
      thr_daddr_q <= `PEM_RST_WORD;
      cmpl_iaddr_q <= `PEM_RST_WORD;
      opnd_daddr_q <= `PEM_RST_WORD;
    end else begin
      thr_iaddr_q <= thr_iaddr;
      thr_daddr_q <= thr_daddr;
      cmpl_iaddr_q <= cmpl_iaddr;
      opnd_daddr_q <= opnd_daddr;
    end
  end

  // Samples move only on firing, which itself needs the arm bit.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sia_q <= `PEM_RST_WORD;
      sda_q <= `PEM_RST_WORD;
    end else if (mon_fire) begin
      if (thr_fire) begin
        sia_q <= thr_iaddr_q;
        sda_q <= thr_daddr_q;
      end else begin
        sia_q <= cmpl_iaddr_q;
        sda_q <= opnd_daddr_q;
      end
    end
  end

  // ****************************************************************
  // Pending request and exception arbitration
  // ****************************************************************

  logic pend_q;
  logic mon_taken;
  logic exc_req_q;
  pem_pkg::pem_src_e exc_src_q;
  logic [19:0] exc_vec_q;

  assign mon_taken = exc_ack & exc_req_q & (exc_src_q == pem_pkg::PEM_SRC_MON);

  // A new firing in the cycle of the acknowledge keeps the request set.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pend_q <= 1'b0;
    end else if (mon_fire) begin
      pend_q <= 1'b1;
    end else if (mon_taken) begin
      pend_q <= 1'b0;
    end
  end

  // The offered source is held until acknowledged so the taker sees a stable
  // vector; a higher source arriving meanwhile is offered next.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      exc_req_q <= 1'b0;
      exc_src_q <= pem_pkg::PEM_SRC_NONE;
      exc_vec_q <= 20'h00000;
    end else if (!exc_req_q || exc_ack) begin
      exc_req_q <= 1'b0;
      exc_src_q <= pem_pkg::PEM_SRC_NONE;
      exc_vec_q <= 20'h00000;
      // Requests wait here while the external enable is clear.
      if (external_irq_enable_bit) begin
        if (ext_irq_req) begin
          exc_req_q <= 1'b1;
          exc_src_q <= pem_pkg::PEM_SRC_EXT;
          exc_vec_q <= EXT_VEC;
        end else if (pend_q && !mon_taken) begin
          exc_req_q <= 1'b1;
          exc_src_q <= pem_pkg::PEM_SRC_MON;
          exc_vec_q <= `PEM_VEC_MON;
        end else if (dec_irq_req) begin
          exc_req_q <= 1'b1;
          exc_src_q <= pem_pkg::PEM_SRC_DEC;
          exc_vec_q <= DEC_VEC;
        end
      end
    end
  end

  assign exc_req = exc_req_q;
  assign exc_src = exc_src_q;
  assign exc_vector = exc_vec_q;
  assign monitor_interrupt_pending = pend_q;

  // ****************************************************************
  // Read path
  // ****************************************************************

  logic [31:0] rd_mux;

  always_comb begin
    case (spr_num)
      `PEM_SPR_CTRL0: rd_mux = ctrl0_q;
      `PEM_SPR_CTRL1: rd_mux = ctrl1_q;
      `PEM_SPR_CNT1: rd_mux = cnt_val[0];
      `PEM_SPR_CNT2: rd_mux = cnt_val[1];
      `PEM_SPR_CNT3: rd_mux = cnt_val[2];
      `PEM_SPR_CNT4: rd_mux = cnt_val[3];
      `PEM_SPR_SIA: rd_mux = sia_q;
      `PEM_SPR_SDA: rd_mux = sda_q;
      default: rd_mux = `PEM_RST_WORD;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdata_q <= `PEM_RST_WORD;
      rvalid_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      rvalid_q <= spr_rd;
      rdata_q <= (spr_rd && acc_ok) ? rd_mux : `PEM_RST_WORD;
      fault_q <= acc_any & is_mapped(spr_num) & ~spr_supervisor;
    end
  end

  assign spr_rdata = rdata_q;
  assign spr_rvalid = rvalid_q;
  assign spr_fault = fault_q;

endmodule
`default_nettype wire

// *** rtl/pem_pkg.sv ***
// Types shared by the performance event monitor.
`default_nettype none
package pem_pkg;
  typedef logic [31:0] pem_word_t;
  typedef enum logic [1:0] {
    PEM_SRC_NONE = 2'b00,
    PEM_SRC_EXT = 2'b01,
    PEM_SRC_MON = 2'b10,
    PEM_SRC_DEC = 2'b11
  } pem_src_e;
endpackage
`default_nettype wire

// *** tb/pem_monitor_props.sv ***
// Port checker of the performance event monitor, bound to the top module.
`default_nettype none
`include "pem_cfg.svh"
module pem_props_chk (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [9:0] spr_num,
  input wire logic spr_rd,
  input wire logic spr_wr,
  input wire logic spr_supervisor,
  input wire logic [31:0] spr_rdata,
  input wire logic spr_rvalid,
  input wire logic spr_fault,
  input wire logic external_irq_enable_bit,
  input wire logic ext_irq_req,
  input wire logic exc_ack,
  input wire logic exc_req,
  input wire pem_pkg::pem_src_e exc_src,
  input wire logic [19:0] exc_vector,
  input wire logic monitor_interrupt_pending
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  logic mapped;
  assign mapped = (spr_num >= `PEM_SPR_CTRL0) && (spr_num <= `PEM_SPR_SDA);
  chk_read_answer: assert property (spr_rd |=> spr_rvalid)
    else $error("read not answered");
  chk_answer_cause: assert property (spr_rvalid |-> $past(spr_rd))
    else $error("answer without read");
  chk_rdata_idle: assert property (!spr_rvalid |-> spr_rdata == 32'h0)
    else $error("read data outside answer");
  chk_user_refused: assert property ((spr_rd || spr_wr) && !spr_supervisor && mapped
    |=> spr_fault && spr_rdata == 32'h0) else $error("user access not refused");
  chk_mon_vector: assert property (exc_req && exc_src == pem_pkg::PEM_SRC_MON
    |-> exc_vector == `PEM_VEC_MON) else $error("monitor vector wrong");
  chk_offer_stands: assert property (exc_req && !exc_ack
    |=> exc_req && $stable(exc_src)) else $error("offer dropped before ack");
  chk_masked_quiet: assert property ($rose(exc_req) |-> $past(external_irq_enable_bit))
    else $error("offer while masked");
  chk_ext_first: assert property ($rose(exc_req) && $past(ext_irq_req)
    |-> exc_src == pem_pkg::PEM_SRC_EXT) else $error("external not first");
  chk_mon_over_dec: assert property ($rose(exc_req) && $past(monitor_interrupt_pending)
    && !$past(ext_irq_req) |-> exc_src == pem_pkg::PEM_SRC_MON)
    else $error("monitor not above decrementer");
  chk_pend_offered: assert property (monitor_interrupt_pending && external_irq_enable_bit
    && !ext_irq_req && !exc_req |=> exc_req) else $error("pending not offered");
endmodule
bind pem_monitor pem_props_chk u_chk (.clk_sys(clk_sys), .srst(srst), .spr_num(spr_num),
  .spr_rd(spr_rd), .spr_wr(spr_wr), .spr_supervisor(spr_supervisor), .spr_rdata(spr_rdata),
  .spr_rvalid(spr_rvalid), .spr_fault(spr_fault),
  .external_irq_enable_bit(external_irq_enable_bit), .ext_irq_req(ext_irq_req),
  .exc_ack(exc_ack), .exc_req(exc_req), .exc_src(exc_src), .exc_vector(exc_vector),
  .monitor_interrupt_pending(monitor_interrupt_pending));
`default_nettype wire

// *** tb/pem_pipe_model.sv ***
// Pipeline event source and exception logic model facing the monitor.
`default_nettype none
module pem_pipe_model (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic exc_req,
  input wire pem_pkg::pem_src_e exc_src,
  output logic [95:0] evt_count,
  output logic [31:0] tb_lower,
  output logic [31:0] thr_iaddr,
  output logic [31:0] thr_daddr,
  output logic [31:0] cmpl_iaddr,
  output logic [31:0] opnd_daddr,
  output logic ext_irq_req,
  output logic dec_irq_req,
  output logic exc_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  pem_pkg::pem_src_e taken[$];
  int dly;
  initial begin
    evt_count = 96'h0;
    tb_lower = 32'h0;
    ext_irq_req = 1'b0;
    dec_irq_req = 1'b0;
    exc_ack = 1'b0;
    dly = 1;
  end
  always @(posedge clk_sys) begin
    tb_lower <= srst ? 32'h0 : tb_lower + 32'h1;
  end
  // Acks come after a random wait so that offers are seen held for several cycles.
  always @(posedge clk_sys) begin
    exc_ack <= 1'b0;
    if (exc_req && !exc_ack) begin
      if (dly == 0) begin
        exc_ack <= 1'b1;
        taken.push_back(exc_src);
        if (exc_src == pem_pkg::PEM_SRC_EXT) ext_irq_req <= 1'b0;
        if (exc_src == pem_pkg::PEM_SRC_DEC) dec_irq_req <= 1'b0;
        dly <= $urandom_range(3, 0);
      end else begin
        dly <= dly - 1;
      end
    end
  end
  task automatic set_addr(input logic [31:0] a, input logic [31:0] b,
                          input logic [31:0] c, input logic [31:0] d);
    cmpl_iaddr = a;
    opnd_daddr = b;
    thr_iaddr = c;
    thr_daddr = d;
  endtask
  task automatic raise(input logic e, input logic d);
    ext_irq_req = e;
    dec_irq_req = d;
  endtask
  // Code 6 carries noise that no counter selects, to expose a wrong event slice.
  task automatic burst(input int code, input int n, input int lo, input int hi, output int sum);
    int v;
    sum = 0;
    repeat (n) begin
      @(posedge clk_sys);
      #1;
      v = $urandom_range(hi, lo);
      evt_count = 96'h0;
      evt_count[code*3 +: 3] = v[2:0];
      evt_count[18 +: 3] = 3'h7;
      sum += v;
    end
    @(posedge clk_sys);
    #1;
    evt_count = 96'h0;
  endtask
endmodule
`default_nettype wire

// *** tb/pem_testbench.sv ***
// Self-checking testbench of the performance event monitor.
`default_nettype none
`include "pem_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, srst, spr_wr, spr_rd, spr_supervisor, external_irq_enable_bit;
  logic [9:0] spr_num;
  logic [31:0] spr_wdata, spr_rdata, tb_lower, thr_iaddr, thr_daddr, cmpl_iaddr, opnd_daddr;
  logic spr_rvalid, spr_fault, ext_irq_req, dec_irq_req, exc_ack, exc_req, pend, rv, flt;
  logic [95:0] evt_count;
  logic [19:0] exc_vector;
  pem_pkg::pem_src_e exc_src;
  int err_total, compares, cyc;
  logic [31:0] mdl[4];
  logic [9:0] cnum[4] = '{`PEM_SPR_CNT1, `PEM_SPR_CNT2, `PEM_SPR_CNT3, `PEM_SPR_CNT4};
  pem_monitor dut (.clk_sys(clk_sys), .srst(srst), .spr_num(spr_num), .spr_wr(spr_wr),
    .spr_rd(spr_rd), .spr_wdata(spr_wdata), .spr_supervisor(spr_supervisor),
    .spr_rdata(spr_rdata), .spr_rvalid(spr_rvalid), .spr_fault(spr_fault),
    .evt_count(evt_count), .tb_lower(tb_lower), .thr_iaddr(thr_iaddr), .thr_daddr(thr_daddr),
    .cmpl_iaddr(cmpl_iaddr), .opnd_daddr(opnd_daddr),
    .external_irq_enable_bit(external_irq_enable_bit), .ext_irq_req(ext_irq_req),
    .dec_irq_req(dec_irq_req), .exc_ack(exc_ack), .exc_req(exc_req), .exc_src(exc_src),
    .exc_vector(exc_vector), .monitor_interrupt_pending(pend));
  pem_pipe_model p (.clk_sys(clk_sys), .srst(srst), .exc_req(exc_req), .exc_src(exc_src),
    .evt_count(evt_count), .tb_lower(tb_lower), .thr_iaddr(thr_iaddr), .thr_daddr(thr_daddr),
    .cmpl_iaddr(cmpl_iaddr), .opnd_daddr(opnd_daddr), .ext_irq_req(ext_irq_req),
    .dec_irq_req(dec_irq_req), .exc_ack(exc_ack));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", name, exp, got);
      err_total++;
    end
  endtask
  task automatic wr(input logic [9:0] num, input logic [31:0] data, input logic sup);
    @(posedge clk_sys);
    #1;
    spr_num = num;
    spr_wdata = data;
    spr_supervisor = sup;
    spr_wr = 1'b1;
    @(posedge clk_sys);
    #1;
    spr_wr = 1'b0;
    spr_supervisor = 1'b1;
  endtask
  task automatic rd(input logic [9:0] num, input logic sup, output logic [31:0] data);
    @(posedge clk_sys);
    #1;
    spr_num = num;
    spr_supervisor = sup;
    spr_rd = 1'b1;
    @(posedge clk_sys);
    #1;
    spr_rd = 1'b0;
    spr_supervisor = 1'b1;
    data = spr_rdata;
    rv = spr_rvalid;
    flt = spr_fault;
  endtask
  task automatic rdc(input logic [9:0] num, input logic [31:0] exp);
    logic [31:0] d;
    rd(num, 1'b1, d);
    chk("spr_rvalid", 32'h1, {31'h0, rv});
    chk("spr_rdata", exp, d);
  endtask
  task automatic wait_taken(input int n);
    for (int j = 0; j < 300 && p.taken.size() < n; j++) @(posedge clk_sys);
    #1;
    chk("offers taken", n, p.taken.size());
  endtask
  initial begin
    logic [31:0] d, d2, a, b, c, e;
    int sum;
    pem_pkg::pem_src_e want[3];
    {spr_wr, spr_rd, spr_num, spr_wdata, external_irq_enable_bit} = '0;
    spr_supervisor = 1'b1;
    srst = 1'b1;
    sum = $urandom(12);
    repeat (5) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    for (int i = 0; i < 8; i++) rdc(`PEM_SPR_CTRL0 + 10'(i), 32'h0);
    rd(10'h3c0, 1'b1, d);
    chk("unmapped", 32'h0, {d[31:1], d[0] | flt});
    rd(cnum[0], 1'b0, d);
    chk("user fault", 32'h1, {d[31:1], d[0] | flt});
    wr(cnum[0], 32'h5, 1'b0);
    rdc(cnum[0], 32'h0);
    wr(`PEM_SPR_SIA, 32'h1234, 1'b1);
    rdc(`PEM_SPR_SIA, 32'h0);
    // Loads stay non-negative while any interrupt path is armed.
    for (int i = 0; i < 4; i++) begin
      mdl[i] = $urandom & 32'h3fff_ffff;
      wr(cnum[i], mdl[i], 1'b1);
    end
    for (int i = 0; i < 4; i++) rdc(cnum[i], mdl[i]);
    wr(`PEM_SPR_CTRL0, 32'h1 << `PEM_C0_SEL1_LO, 1'b1);
    rd(cnum[0], 1'b1, d);
    rd(cnum[0], 1'b1, d2);
    chk("cycle count", 32'h2, d2 - d);
    wr(cnum[0], mdl[0], 1'b1);
    rdc(cnum[0], mdl[0] + 32'h1);
    wr(`PEM_SPR_CTRL0, 32'h0, 1'b1);
    rd(cnum[0], 1'b1, d);
    rd(cnum[0], 1'b1, d2);
    chk("hold count", 32'h0, d2 - d);
    wr(`PEM_SPR_CTRL0, 32'h5, 1'b1);
    wr(`PEM_SPR_CTRL1, 32'h5 << `PEM_C1_SEL4_LO, 1'b1);
    rdc(`PEM_SPR_CTRL1, 32'h5 << `PEM_C1_SEL4_LO);
    mdl[3] = 32'hffff_fff0;
    wr(cnum[3], mdl[3], 1'b1);
    p.burst(5, 40, 0, 7, sum);
    mdl[1] += sum;
    mdl[3] += sum;
    rdc(cnum[1], mdl[1]);
    rdc(cnum[3], mdl[3]);
    rdc(cnum[2], mdl[2]);
    for (int k = 0; k < 2; k++) begin
      {a, b, c, e} = {$urandom, $urandom, $urandom, $urandom};
      p.set_addr(a, b, c, e);
      wr(`PEM_SPR_CTRL0, 32'h0, 1'b1);
      wr(`PEM_SPR_CTRL1, 32'h0, 1'b1);
      wr(cnum[3], 32'h0, 1'b1);
      wr(cnum[0], k ? 32'h7fff_ffff : 32'h7fff_fffc, 1'b1);
      wr(`PEM_SPR_CTRL0, (32'h1 << `PEM_C0_ARM) | (32'h1 << `PEM_C0_CTR_IRQ_EN)
         | ((k ? 32'h9 : 32'h1) << `PEM_C0_SEL1_LO) | ((k ? 32'h0 : 32'h1) << `PEM_C0_FREEZE),
         1'b1);
      if (k) p.burst(9, 1, 1, 1, sum);
      for (int j = 0; j < 50 && pend !== 1'b1; j++) @(posedge clk_sys);
      repeat (4) @(posedge clk_sys);
      #1;
      chk("pending", 32'h1, {31'h0, pend});
      chk("masked offer", 32'h0, {31'h0, exc_req});
      rd(`PEM_SPR_CTRL0, 1'b1, d);
      chk("arm bit", 32'h0, {31'h0, d[`PEM_C0_ARM]});
      rdc(`PEM_SPR_SIA, k ? c : a);
      rdc(`PEM_SPR_SDA, k ? e : b);
      p.set_addr(~a, ~b, ~c, ~e);
      repeat (3) @(posedge clk_sys);
      rdc(`PEM_SPR_SIA, k ? c : a);
      rdc(`PEM_SPR_SDA, k ? e : b);
      rd(cnum[0], 1'b1, d);
      p.burst(9, 3, 1, 2, sum);
      rd(cnum[0], 1'b1, d2);
      chk("frozen", k ? sum : 32'h0, d2 - d);
      if (k) p.raise(1'b1, 1'b1);
      external_irq_enable_bit = 1'b1;
      wait_taken(k ? 3 : 1);
      if (k) begin
        want = '{pem_pkg::PEM_SRC_EXT, pem_pkg::PEM_SRC_MON, pem_pkg::PEM_SRC_DEC};
      end else begin
        want = '{pem_pkg::PEM_SRC_MON, pem_pkg::PEM_SRC_MON, pem_pkg::PEM_SRC_MON};
      end
      for (int i = 0; i < p.taken.size(); i++) begin
        chk("offer source", {30'h0, want[i]}, {30'h0, p.taken[i]});
      end
      p.taken.delete();
      external_irq_enable_bit = 1'b0;
    end
    external_irq_enable_bit = 1'b1;
    wr(`PEM_SPR_CTRL0, (32'h1 << `PEM_C0_ARM) | (32'h1 << `PEM_C0_TB_IRQ_EN)
       | (32'h3 << `PEM_C0_TB_SEL_LO), 1'b1);
    wait_taken(1);
    chk("time base source", {30'h0, pem_pkg::PEM_SRC_MON}, {30'h0, p.taken[0]});
    rd(`PEM_SPR_CTRL0, 1'b1, d);
    chk("arm bit", 32'h0, {31'h0, d[`PEM_C0_ARM]});
    tally_and_finish();
  end
endmodule
`default_nettype wire
